// [logic/slcr_integrity.sv]
`include "slcr_params.svh"
module slcr_integrity
    import slcr_pkg::*;
(
    input wire logic [7:0] cfg_byte,
    input wire logic [7:0] ident_byte,
    input wire logic [7:0] client_byte,
    output logic [7:0] check_byte
);
    // Self-test bits never reach this sum, so flipping them keeps it
    function automatic logic [7:0] mix(input logic [7:0] a,
                                       input logic [7:0] b);
        mix = {a[6:0], a[7]} ^ b;
    endfunction

    always_comb begin
        check_byte = mix(mix(cfg_byte, ident_byte), client_byte);
    end
endmodule

// [logic/slcr_params.svh]
`ifndef SLCR_PARAMS_SVH
`define SLCR_PARAMS_SVH

`define SLCR_OFS_SPI_CFG 8'h3D
`define SLCR_OFS_IDENT 8'h3E
`define SLCR_OFS_CLIENT 8'h3F
`define SLCR_OFS_FPC5 8'h44
`define SLCR_OFS_ENDLOCK 8'h20
`define SLCR_RST_BYTE 8'h00
`define SLCR_RST_LOCK 1'b0
`define SLCR_BIT_RSVD 7
`define SLCR_BIT_WIDTH 6
`define SLCR_LEN_HI 5
`define SLCR_LEN_LO 4
`define SLCR_SEED_HI 3
`define SLCR_SEED_LO 0
`define SLCR_BIT_LOCK 0
`define SLCR_ST_HI 7
`define SLCR_ST_LO 4
`define SLCR_RSV_HI 3
`define SLCR_RSV_LO 0
`define SLCR_LEN8 2'h0
`define SLCR_LEN4 2'h1
`define SLCR_WIDTH_SMALL 5'h0C
`define SLCR_WIDTH_LARGE 5'h10
`define SLCR_POLY8 8'h2F
`define SLCR_POLY4 8'h01
`define SLCR_POLY3 8'h03
`define SLCR_SEED8_DEF 8'hFF
`define SLCR_SEED4_DEF 8'h0A
`define SLCR_SEED3_DEF 8'h07
`define SLCR_CLEN8 4'h8
`define SLCR_CLEN4 4'h4
`define SLCR_CLEN3 4'h3
`define SLCR_ADDR_DEF 7'h60
`define SLCR_READ_DEF 8'h60
`define SLCR_ZERO_BYTE 8'h00
`define SLCR_ZERO_NIB 4'h0
`define SLCR_ZERO_BIT 1'b0
`define SLCR_ONE_BIT 1'b1

`endif

// [logic/slcr_pkg.sv]
package slcr_pkg;
    typedef logic [7:0] slcr_byte_t;
    typedef enum logic [1:0] {
        SLCR_CHK8 = 2'h0,
        SLCR_CHK4 = 2'h1,
        SLCR_CHK3 = 2'h2
    } slcr_chk_e;
    typedef struct packed {
        slcr_byte_t cfg;
        slcr_byte_t ident;
        slcr_byte_t client;
        slcr_byte_t fpc5;
        logic lock;
        logic [4:0] width;
        slcr_chk_e chk;
        slcr_byte_t poly;
        slcr_byte_t seed;
        logic [3:0] clen;
        slcr_byte_t rdata;
        logic rvalid;
        slcr_byte_t crc_acc;
        logic [6:0] addr;
    } slcr_state_s;
endpackage

// [logic/slcr_top.sv]
`include "slcr_params.svh"
module slcr_top
    import slcr_pkg::*;
#(
    // Arbitrary neutral identifier code
    parameter logic [7:0] IDENT_CODE = 8'h5A
)(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic cmd_start,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    output logic init_complete_lock,
    output logic [4:0] payload_width,
    output logic [1:0] check_length_select,
    output logic [7:0] check_poly,
    output logic [7:0] check_seed,
    output logic [3:0] check_bits,
    output logic [6:0] client_addr,
    output logic [7:0] array_check
);
    slcr_state_s s_reg;
    slcr_state_s s_next;
    logic [7:0] chk_w;

    function automatic slcr_chk_e len_decode(input logic [1:0] code);
        if (code == `SLCR_LEN8) begin
            len_decode = SLCR_CHK8;
        end else if (code == `SLCR_LEN4) begin
            len_decode = SLCR_CHK4;
        end else begin
            len_decode = SLCR_CHK3;
        end
    endfunction

    function automatic logic [7:0] seed_of(input slcr_chk_e c,
                                           input logic [3:0] sd);
        logic z;
        z = (sd == `SLCR_ZERO_NIB);
        unique case (c)
            SLCR_CHK8: seed_of = z ? `SLCR_SEED8_DEF : {4'h0, sd};
            SLCR_CHK4: seed_of = z ? `SLCR_SEED4_DEF : {4'h0, sd};
            default: seed_of = z ? `SLCR_SEED3_DEF : {5'h00, sd[2:0]};
        endcase
    endfunction

    function automatic logic [7:0] poly_of(input slcr_chk_e c);
        unique case (c)
            SLCR_CHK8: poly_of = `SLCR_POLY8;
            SLCR_CHK4: poly_of = `SLCR_POLY4;
            default: poly_of = `SLCR_POLY3;
        endcase
    endfunction

    function automatic logic [3:0] clen_of(input slcr_chk_e c);
        unique case (c)
            SLCR_CHK8: clen_of = `SLCR_CLEN8;
            SLCR_CHK4: clen_of = `SLCR_CLEN4;
            default: clen_of = `SLCR_CLEN3;
        endcase
    endfunction

    function automatic logic is_zero(input slcr_byte_t v);
        is_zero = (v == `SLCR_ZERO_BYTE);
    endfunction

    // Stored zero reads as the fixed identifier code
    function automatic slcr_byte_t ident_view(input slcr_byte_t v);
        if (is_zero(v)) begin
            ident_view = IDENT_CODE;
        end else begin
            ident_view = v;
        end
    endfunction

    // Stored zero reads as the default client address
    function automatic slcr_byte_t client_view(input slcr_byte_t v);
        if (is_zero(v)) begin
            client_view = `SLCR_READ_DEF;
        end else begin
            client_view = v;
        end
    endfunction

    slcr_integrity u_integrity (
        .cfg_byte(s_reg.cfg),
        .ident_byte(s_reg.ident),
        .client_byte(s_reg.client),
        .check_byte(chk_w)
    );

    always_comb begin
        slcr_chk_e c;
        logic wr_ok;
        logic client_dflt;
        logic [7:0] rsv_w;
        c = len_decode(s_reg.cfg[`SLCR_LEN_HI:`SLCR_LEN_LO]);
        wr_ok = reg_wr && !s_reg.lock;
        client_dflt = is_zero(s_reg.client);
        // Self-test select bits are left out; only the reserved nibble counts
        rsv_w = {`SLCR_ZERO_NIB, s_reg.fpc5[`SLCR_RSV_HI:`SLCR_RSV_LO]};
        s_next = s_reg;
        s_next.rvalid = reg_rd;
        // One register stage behind the stored contents
        s_next.crc_acc = chk_w ^ rsv_w;
        if (wr_ok) begin
            unique case (reg_addr)
                `SLCR_OFS_SPI_CFG: begin
                    // Reserved bit kept as written; only the integrity check byte uses it
                    s_next.cfg = reg_wdata;
                end
                `SLCR_OFS_IDENT: begin
                    s_next.ident = reg_wdata;
                end
                `SLCR_OFS_CLIENT: begin
                    s_next.client = reg_wdata;
                end
                `SLCR_OFS_FPC5: begin
                    s_next.fpc5 = reg_wdata;
                end
                `SLCR_OFS_ENDLOCK: begin
                    // Once set, only reset can drop it
                    s_next.lock = reg_wdata[`SLCR_BIT_LOCK];
                end
                default: begin
                    s_next.lock = s_reg.lock;
                end
            endcase
        end
        // Payload width follows the stored width bit one cycle later, with no command needed; framing samples it per command
        if (s_reg.cfg[`SLCR_BIT_WIDTH]) begin
            s_next.width = `SLCR_WIDTH_LARGE;
        end else begin
            s_next.width = `SLCR_WIDTH_SMALL;
        end
        // Check settings latch only at a command start, never mid frame
        if (cmd_start) begin
            s_next.chk = c;
            s_next.poly = poly_of(c);
            s_next.clen = clen_of(c);
            s_next.seed = seed_of(c,
                s_reg.cfg[`SLCR_SEED_HI:`SLCR_SEED_LO]);
        end
        if (client_dflt) begin
            s_next.addr = `SLCR_ADDR_DEF;
        end else begin
            s_next.addr = s_reg.client[6:0];
        end
        s_next.rdata = `SLCR_ZERO_BYTE;
        if (reg_rd) begin
            unique case (reg_addr)
                `SLCR_OFS_SPI_CFG: begin
                    s_next.rdata = s_reg.cfg;
                end
                `SLCR_OFS_IDENT: begin
                    s_next.rdata = ident_view(s_reg.ident);
                end
                `SLCR_OFS_CLIENT: begin
                    // Readable whatever interface mode is in use
                    s_next.rdata = client_view(s_reg.client);
                end
                `SLCR_OFS_FPC5: begin
                    s_next.rdata = s_reg.fpc5;
                end
                `SLCR_OFS_ENDLOCK: begin
                    s_next.rdata = {7'h00, s_reg.lock};
                end
                default: begin
                    s_next.rdata = `SLCR_ZERO_BYTE;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_reg.cfg <= `SLCR_RST_BYTE;
            s_reg.ident <= `SLCR_RST_BYTE;
            s_reg.client <= `SLCR_RST_BYTE;
            s_reg.fpc5 <= `SLCR_RST_BYTE;
            s_reg.lock <= `SLCR_RST_LOCK;
            s_reg.width <= `SLCR_WIDTH_SMALL;
            s_reg.chk <= SLCR_CHK8;
            s_reg.poly <= `SLCR_POLY8;
            s_reg.seed <= `SLCR_SEED8_DEF;
            s_reg.clen <= `SLCR_CLEN8;
            s_reg.rdata <= `SLCR_ZERO_BYTE;
            s_reg.rvalid <= `SLCR_ZERO_BIT;
            s_reg.crc_acc <= `SLCR_ZERO_BYTE;
            s_reg.addr <= `SLCR_ADDR_DEF;
        end else begin
            s_reg <= s_next;
        end
    end

    assign reg_rdata = s_reg.rdata;
    assign reg_rvalid = s_reg.rvalid;
    assign init_complete_lock = s_reg.lock;
    assign payload_width = s_reg.width;
    assign check_length_select = s_reg.chk;
    assign check_poly = s_reg.poly;
    assign check_seed = s_reg.seed;
    assign check_bits = s_reg.clen;
    assign client_addr = s_reg.addr;
    assign array_check = s_reg.crc_acc;
endmodule

// [sim/slcr_host.sv]
module slcr_host (
    input wire logic core_clk,
    input wire logic reg_rvalid,
    input wire logic [7:0] reg_rdata,
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic cmd_start
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        {reg_wr, reg_rd, cmd_start, reg_addr, reg_wdata} = 19'h00000;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v,
                      output logic ok);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        for (int i = 0; i < 4 && reg_rvalid !== 1'b1; i++) begin
            @(posedge core_clk);
            #1;
        end
        ok = reg_rvalid === 1'b1;
        v = reg_rdata;
    endtask
    task automatic cmd();
        @(posedge core_clk);
        cmd_start <= 1'b1;
        @(posedge core_clk);
        cmd_start <= 1'b0;
    endtask
endmodule

// [sim/slcr_top_monitor.sv]
module slcr_top_monitor (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic cmd_start,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid,
    input wire logic init_complete_lock,
    input wire logic [4:0] payload_width,
    input wire logic [1:0] check_length_select,
    input wire logic [7:0] check_poly,
    input wire logic [3:0] check_bits,
    input wire logic [6:0] client_addr,
    input wire logic [7:0] array_check
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] rsv_seen;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // Mirror of the reserved nibble last written to the self-test register
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rsv_seen <= 4'h0;
        end else if (reg_wr && !init_complete_lock && reg_addr == 8'h44) begin
            rsv_seen <= reg_wdata[3:0];
        end
    end
    a_width_follow: assert property (
        reg_wr && !init_complete_lock && reg_addr == 8'h3D |=> ##1
        payload_width == ($past(reg_wdata[6], 2) ? 5'h10 : 5'h0C))
        else $error("bad width");
    a_code_map: assert property (
        (check_length_select == 2'h0)
        ? (check_poly == 8'h2F && check_bits == 4'h8)
        : (check_length_select == 2'h1)
        ? (check_poly == 8'h01 && check_bits == 4'h4)
        : (check_length_select == 2'h2 && check_poly == 8'h03
           && check_bits == 4'h3))
        else $error("bad code");
    a_reset_eight: assert property (
        $rose(rst_n) |-> check_bits == 4'h8) else $error("bad reset");
    a_settle_cmd: assert property (
        !cmd_start |=> $stable(check_length_select) && $stable(check_poly))
        else $error("early change");
    a_read_answer: assert property (
        reg_rvalid == $past(reg_rd)) else $error("bad rvalid");
    // Only reads with no write in this or the last cycle, so the address lag cannot mislead
    a_client_read: assert property (
        reg_rd && reg_addr == 8'h3F && !reg_wr && !$past(reg_wr)
        |=> reg_rdata[6:0] == $past(client_addr)) else $error("bad client");
    a_lock_sticky: assert property (
        init_complete_lock |=> init_complete_lock) else $error("lock lost");
    a_lock_refuse: assert property (
        init_complete_lock && reg_wr |=> $stable(array_check)[*2])
        else $error("locked write");
    a_selftest_out: assert property (
        reg_wr && reg_addr == 8'h44 && reg_wdata[3:0] == rsv_seen
        && !$past(reg_wr)
        |=> $stable(array_check)[*2]) else $error("selftest in check");
    c_locked: cover property (init_complete_lock && reg_wr);
    c_three: cover property (check_bits == 4'h3);
    c_client: cover property (reg_rvalid && reg_rdata == 8'h60);
endmodule
bind slcr_top slcr_top_monitor slcr_top_monitor_inst (.*);

// [sim/tb_serial_link_config_registers.sv]
module tb_serial_link_config_registers;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [7:0] IDC = 8'hA3; // Arbitrary identifier code
    logic core_clk, rst_n, reg_wr, reg_rd, cmd_start, reg_rvalid, ok;
    logic init_complete_lock;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, check_poly, check_seed;
    logic [7:0] array_check, d, c, a0;
    logic [7:0] p = 8'h00;
    logic [7:0] ca [3];
    logic [4:0] payload_width;
    logic [1:0] check_length_select;
    logic [3:0] check_bits;
    logic [6:0] client_addr;
    logic [31:0] r;
    logic [31:0] rs = 32'hF73F;
    int errors = 0;
    int checked = 0;
    logic [7:0] poly_t [4] = '{8'h2F, 8'h01, 8'h03, 8'h03};
    logic [3:0] bits_t [4] = '{4'h8, 4'h4, 4'h3, 4'h3};
    slcr_top #(.IDENT_CODE(IDC)) slcr_top_inst (.*);
    slcr_host slcr_host_inst (.*);
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    function automatic logic [31:0] xs();
        rs ^= rs << 13;
        rs ^= rs >> 17;
        rs ^= rs << 5;
        return rs;
    endfunction
    function automatic logic [7:0] e_seed(input logic [7:0] v);
        if (v[3:0] == 4'h0) return v[5:4] == 2'h0 ? 8'hFF
            : v[5:4] == 2'h1 ? 8'h0A : 8'h07;
        return v[5] ? {5'h00, v[2:0]} : {4'h0, v[3:0]};
    endfunction
    task automatic cmp(input string n, input logic [7:0] e,
                       input logic [7:0] g);
        checked++;
        if (g !== e) begin
            errors++;
            $display("mismatch %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic tally_and_finish();
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // A lost answer ends the run at once
    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        slcr_host_inst.rd(a, d, ok);
        if (ok !== 1'b1) begin
            errors++;
            tally_and_finish();
        end else cmp("read", e, d);
    endtask
    initial begin
        rst_n = 1'b0;
        repeat (5) @(posedge core_clk);
        rst_n <= 1'b1;
        #1;
        cmp("width", 5'h0C, payload_width);
        cmp("bits", 4'h8, check_bits);
        cmp("seed", 8'hFF, check_seed);
        rdchk(8'h3D, 8'h00);
        rdchk(8'h3E, IDC);
        for (int k = 0; k < 8; k++) begin
            r = xs();
            c = {r[7:6], k[1:0], k < 4 ? 4'h0 : r[3:0]};
            slcr_host_inst.wr(8'h3D, c);
            repeat (2) @(posedge core_clk);
            #1;
            cmp("bits_held", bits_t[p[5:4]], check_bits);
            cmp("seed_held", e_seed(p), check_seed);
            cmp("width", c[6] ? 5'h10 : 5'h0C, payload_width);
            slcr_host_inst.cmd();
            @(posedge core_clk);
            #1;
            cmp("poly", poly_t[c[5:4]], check_poly);
            cmp("bits", bits_t[c[5:4]], check_bits);
            cmp("seed", e_seed(c), check_seed);
            cmp("len", {6'h00, (c[5] ? 2'h2 : c[5:4])},
                {6'h00, check_length_select});
            rdchk(8'h3D, c);
            p = c;
        end
        a0 = array_check;
        r = xs() | 32'h1;
        slcr_host_inst.wr(8'h3E, r[7:0]);
        rdchk(8'h3E, r[7:0]);
        cmp("integ_chg", 8'h01, {7'h00, array_check !== a0});
        slcr_host_inst.wr(8'h3E, 8'h00);
        rdchk(8'h3E, IDC);
        ca = '{8'h80, r[15:8] | 8'h01, 8'h00};
        foreach (ca[i]) begin
            slcr_host_inst.wr(8'h3F, ca[i]);
            rdchk(8'h3F, ca[i] == 8'h00 ? 8'h60 : ca[i]);
            cmp("client", ca[i] == 8'h00 ? 7'h60 : ca[i][6:0],
                client_addr);
        end
        rdchk(8'h55, 8'h00);
        a0 = array_check;
        slcr_host_inst.wr(8'h44, {r[23:20], 4'h0});
        repeat (3) @(posedge core_clk);
        #1;
        cmp("integrity", a0, array_check);
        rdchk(8'h44, {r[23:20], 4'h0});
        slcr_host_inst.wr(8'h44, {r[23:20], 4'h5});
        repeat (2) @(posedge core_clk);
        #1;
        cmp("integ_rsv", 8'h01, {7'h00, array_check !== a0});
        // Lock goes last: nothing can be configured after it
        slcr_host_inst.wr(8'h20, 8'h01);
        slcr_host_inst.wr(8'h3D, ~p);
        rdchk(8'h3D, p);
        cmp("lock", 8'h01, {7'h00, init_complete_lock});
        // Only a reset drops the lock and the stored values
        @(posedge core_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        #1;
        cmp("lock_rst", 8'h00, {7'h00, init_complete_lock});
        cmp("poly_rst", 8'h2F, check_poly);
        cmp("seed_rst", 8'hFF, check_seed);
        cmp("client_rst", 8'h60, {1'b0, client_addr});
        rdchk(8'h3D, 8'h00);
        rdchk(8'h3F, 8'h60);
        rdchk(8'h3E, IDC);
        tally_and_finish();
    end
endmodule
